// ### design/eca_pkg.sv
// shared constants and carriers for the nonvolatile data array access block
// assumes a single 10 MHz cpu clock and an io space with 6-bit addresses
package eca_pkg;
  // clock and calibrated oscillator rates
  localparam int unsigned CLK_KHZ = 10000;
  localparam int unsigned OSC_KHZ = 8000;
  localparam logic [4:0] OSC_STEP = 5'(OSC_KHZ / 1000);
  localparam logic [4:0] OSC_WRAP = 5'(CLK_KHZ / 1000);

  // io space offsets of the four access registers
  localparam logic [5:0] OFS_CONTROL = 6'h1F;
  localparam logic [5:0] OFS_DATA = 6'h20;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h21;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;

  // array geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned ARRAY_AW = 10;
  localparam logic [11:0] LAST_BYTE_ADDRESS = 12'h3FF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // control register field positions
  localparam int unsigned BIT_READ_STROBE = 0;
  localparam int unsigned BIT_PROG_STROBE = 1;
  localparam int unsigned BIT_MASTER_EN = 2;
  localparam int unsigned BIT_IRQ_EN = 3;
  localparam int unsigned BIT_MODE_LO = 4;
  localparam int unsigned BIT_MODE_HI = 5;

  typedef enum logic [1:0] {
    MODE_ERASE_WRITE = 2'b00,
    MODE_ERASE = 2'b01,
    MODE_WRITE = 2'b10,
    MODE_RESERVED = 2'b11
  } eca_mode_e;

  // reset values
  localparam eca_mode_e MODE_RESET = MODE_ERASE_WRITE;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // cpu halt and master enable windows, in clock cycles
  localparam logic [2:0] MASTER_EN_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;

  // programming times, counted in calibrated oscillator ticks
  localparam int unsigned CAL_WRITE_TICKS = 26368;
  localparam int unsigned SPLIT_TIME_US = 1800;
  localparam int unsigned SPLIT_TICKS = SPLIT_TIME_US * OSC_KHZ / 1000;

  typedef logic [15:0] eca_tick_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [5:0] addr;
    logic [7:0] wrData;
  } eca_io_req_s;

  typedef struct packed {
    logic go;
    eca_mode_e op;
    logic [ARRAY_AW-1:0] addr;
    logic [7:0] data;
  } eca_nv_cmd_s;
endpackage

// ### design/eca_nv_array.sv
// byte array behind the access block, with registered read data
// assumes commands arrive only when the programming timer finishes
`timescale 1ns/1ps
module eca_nv_array (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // programming command
  input wire eca_pkg::eca_nv_cmd_s cmd,
  // read port
  input wire logic rdEn,
  input wire logic [eca_pkg::ARRAY_AW-1:0] rdAddr,
  output logic [7:0] rdData_q
);
  import eca_pkg::*;

  logic [7:0] mem [0:(1 << ARRAY_AW)-1];

  always_ff @(posedge clk) begin
    if (cmd.go) begin
      case (cmd.op)
        MODE_ERASE: mem[cmd.addr] <= ERASED_BYTE;
        // write only can clear bits but never set them
        MODE_WRITE: mem[cmd.addr] <= mem[cmd.addr] & cmd.data;
        MODE_ERASE_WRITE: mem[cmd.addr] <= cmd.data;
        default: ;
      endcase
    end
    if (!reset_n) begin
      rdData_q <= 8'h00;
    end else if (rdEn) begin
      rdData_q <= mem[rdAddr];
    end
  end
endmodule

// ### design/eca_prog_timer.sv
// self-timed programming counter driven by a calibrated oscillator tick
// assumes start is only raised while idle; a run survives reset
`timescale 1ns/1ps
module eca_prog_timer (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic start,
  input wire eca_pkg::eca_tick_t ticks,
  // status
  output logic running,
  output logic done
);
  import eca_pkg::*;

  typedef struct packed {
    logic [3:0] acc;
    eca_tick_t left;
    logic run;
    logic done;
  } eca_timer_s;

  eca_timer_s s_q = '0;
  eca_timer_s s_d;
  logic [4:0] accSum;

  // fractional divider: the oscillator ticks 8 times per 10 clocks
  assign accSum = {1'b0, s_q.acc} + OSC_STEP;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (s_q.run) begin
      if (accSum >= OSC_WRAP) begin
        s_d.acc = 4'(accSum - OSC_WRAP);
        if (s_q.left <= 16'h0001) begin
          s_d.run = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.left = s_q.left - 16'h0001;
        end
      end else begin
        s_d.acc = accSum[3:0];
      end
    end else if (start) begin
      s_d.run = 1'b1;
      s_d.left = ticks;
      s_d.acc = 4'h0;
    end
    // a programming run in flight is allowed to complete through reset
    if (!reset_n && !s_q.run) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign running = s_q.run;
  assign done = s_q.done;
endmodule

// ### design/eca_access_ctrl.sv
// cpu access registers for the on-chip data array: address, data, control
// assumes the cpu core drives io requests on clk and honours cpuStall
`timescale 1ns/1ps
module eca_access_ctrl #(
  parameter eca_pkg::eca_tick_t ATOMIC_TICKS = 16'(eca_pkg::CAL_WRITE_TICKS),
  parameter eca_pkg::eca_tick_t SPLIT_TICKS = 16'(eca_pkg::SPLIT_TICKS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // io space access from the cpu
  input wire eca_pkg::eca_io_req_s io,
  output logic [7:0] ioRdData,
  // core side
  input wire logic globalIrqEnable,
  output logic cpuStall,
  output logic readyIrq
);
  import eca_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [7:0] wrData;
    eca_mode_e mode;
    logic irqEn;
    logic mpe;
    logic [2:0] mpeCnt;
    logic rdPend;
    logic [2:0] stallCnt;
    logic [7:0] rdData;
  } eca_ctrl_s;

  eca_ctrl_s s_q = '0;
  eca_ctrl_s s_d;

  logic selCtrl;
  logic selData;
  logic selAddrLo;
  logic selAddrHi;
  logic wrCtrl;
  logic busy;
  logic launchTry;
  logic writeGo;
  logic readGo;
  logic tmrRunning;
  logic tmrDone;
  eca_tick_t opTicks;
  eca_nv_cmd_s nvCmd;
  logic [7:0] memRdata;
  logic [7:0] ctrlView;

  // address decode
  always_comb begin
    selCtrl = 1'b0;
    selData = 1'b0;
    selAddrLo = 1'b0;
    selAddrHi = 1'b0;
    if (io.addr == OFS_CONTROL) begin
      selCtrl = 1'b1;
    end else if (io.addr == OFS_DATA) begin
      selData = 1'b1;
    end else if (io.addr == OFS_ADDR_LOW) begin
      selAddrLo = 1'b1;
    end else if (io.addr == OFS_ADDR_HIGH) begin
      selAddrHi = 1'b1;
    end
  end

  assign busy = tmrRunning;
  assign wrCtrl = io.wrEn && selCtrl;

  // the strobe only counts while the master enable window is open
  assign launchTry = wrCtrl && io.wrData[BIT_PROG_STROBE] && s_q.mpe && !busy;
  assign writeGo = launchTry && (s_q.mode != MODE_RESERVED);
  // a launch in the same write takes precedence over a read
  assign readGo = wrCtrl && io.wrData[BIT_READ_STROBE] && !busy && !launchTry;

  // duration per mode
  always_comb begin
    case (s_q.mode)
      MODE_ERASE_WRITE: opTicks = ATOMIC_TICKS;
      MODE_ERASE: opTicks = SPLIT_TICKS;
      MODE_WRITE: opTicks = SPLIT_TICKS;
      default: opTicks = 16'h0000;
    endcase
  end

  assign ctrlView = {2'b00, s_q.mode, s_q.irqEn, s_q.mpe, busy, s_q.rdPend};

  always_comb begin
    s_d = s_q;
    // master enable window
    if (s_q.mpe) begin
      if (s_q.mpeCnt <= 3'h1) begin
        s_d.mpe = 1'b0;
        s_d.mpeCnt = 3'h0;
      end else begin
        s_d.mpeCnt = s_q.mpeCnt - 3'h1;
      end
    end
    // cpu halt counter
    if (s_q.stallCnt != 3'h0) begin
      s_d.stallCnt = s_q.stallCnt - 3'h1;
    end
    // a read result lands in the data byte one cycle after the strobe
    if (s_q.rdPend) begin
      s_d.data = memRdata;
      s_d.rdPend = 1'b0;
    end
    if (io.wrEn) begin
      if (selCtrl) begin
        s_d.irqEn = io.wrData[BIT_IRQ_EN];
        // a launching write keeps the armed mode so duration and operation agree
        if (!busy && !launchTry) begin
          s_d.mode = eca_mode_e'(io.wrData[BIT_MODE_HI:BIT_MODE_LO]);
        end
        if (io.wrData[BIT_MASTER_EN]) begin
          s_d.mpe = 1'b1;
          s_d.mpeCnt = MASTER_EN_CYCLES;
        end
      end else if (selData) begin
        s_d.data = io.wrData;
      end else if (selAddrLo && !busy) begin
        s_d.addr[7:0] = io.wrData;
      end else if (selAddrHi && !busy) begin
        s_d.addr[ADDR_W-1:8] = io.wrData[3:0];
      end
    end
    if (launchTry) begin
      s_d.stallCnt = WRITE_STALL_CYCLES;
      s_d.wrData = s_q.data;
      // the strobe consumes the enable window
      s_d.mpe = 1'b0;
      s_d.mpeCnt = 3'h0;
    end
    if (readGo) begin
      s_d.stallCnt = READ_STALL_CYCLES;
      s_d.rdPend = 1'b1;
    end
    // register read data
    if (io.rdEn) begin
      if (selCtrl) begin
        s_d.rdData = ctrlView;
      end else if (selData) begin
        s_d.rdData = s_q.data;
      end else if (selAddrLo) begin
        s_d.rdData = s_q.addr[7:0];
      end else if (selAddrHi) begin
        s_d.rdData = {4'h0, s_q.addr[ADDR_W-1:8]};
      end else begin
        s_d.rdData = 8'h00;
      end
    end
    if (!reset_n) begin
      s_d.irqEn = 1'b0;
      s_d.mpe = 1'b0;
      s_d.mpeCnt = 3'h0;
      s_d.rdPend = 1'b0;
      s_d.stallCnt = 3'h0;
      s_d.rdData = 8'h00;
      // a byte still being programmed keeps its mode, address and data
      if (!busy) begin
        s_d.mode = MODE_RESET;
        s_d.addr = ADDR_RESET;
        s_d.data = DATA_RESET;
        s_d.wrData = DATA_RESET;
      end
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  eca_prog_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(writeGo),
    .ticks(opTicks),
    .running(tmrRunning),
    .done(tmrDone)
  );

  // commit happens at the end of the timed window
  always_comb begin
    nvCmd.go = tmrDone;
    nvCmd.op = s_q.mode;
    // only the low bits reach the array; software keeps the range
    nvCmd.addr = s_q.addr[ARRAY_AW-1:0];
    nvCmd.data = s_q.wrData;
  end

  eca_nv_array u_array (
    .clk(clk),
    .reset_n(reset_n),
    .cmd(nvCmd),
    .rdEn(readGo),
    .rdAddr(s_q.addr[ARRAY_AW-1:0]),
    .rdData_q(memRdata)
  );

  assign cpuStall = (s_q.stallCnt != 3'h0);
  assign readyIrq = s_q.irqEn && globalIrqEnable && !busy;
  assign ioRdData = s_q.rdData;

  // checks
  chk_read_stall: assert property (@(posedge clk) disable iff (!reset_n)
    readGo |=> cpuStall [*4] ##1 !cpuStall)
    else $error("read halt is not four cycles");

  chk_write_stall: assert property (@(posedge clk) disable iff (!reset_n)
    launchTry |=> cpuStall [*2] ##1 !cpuStall)
    else $error("write halt is not two cycles");

  chk_addr_high_zero: assert property (@(posedge clk) disable iff (!reset_n)
    io.rdEn && selAddrHi |=> ioRdData[7:4] == 4'h0)
    else $error("address high upper bits not zero");

  chk_ctrl_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    io.rdEn && selCtrl |=> ioRdData[7:6] == 2'b00)
    else $error("control reserved bits not zero");

  chk_mode_locked: assert property (@(posedge clk) disable iff (!reset_n)
    busy |=> $stable(s_q.mode))
    else $error("mode changed while busy");

  chk_reset_mode: assert property (@(posedge clk)
    $rose(reset_n) && ($past(tmrRunning) == 1'b0) |-> s_q.mode == MODE_RESET)
    else $error("mode not cleared by reset");

  chk_irq_ready: assert property (@(posedge clk) disable iff (!reset_n)
    tmrDone && s_q.irqEn |=> readyIrq || !globalIrqEnable)
    else $error("ready irq missing after completion");

  chk_irq_gated: assert property (@(posedge clk) disable iff (!reset_n)
    readyIrq |-> s_q.irqEn && globalIrqEnable)
    else $error("ready irq without both enables");

  chk_launch_ok: assert property (@(posedge clk) disable iff (!reset_n)
    writeGo |=> busy [*2])
    else $error("valid launch did not start programming");

  chk_no_mpe: assert property (@(posedge clk) disable iff (!reset_n)
    wrCtrl && io.wrData[BIT_PROG_STROBE] && !s_q.mpe && !busy |=> !busy)
    else $error("launch without master enable");

  chk_mpe_timeout: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(s_q.mpe) && !launchTry |-> s_q.mpe [*4] ##1 !s_q.mpe
      or ##[1:3] launchTry)
    else $error("master enable window not four cycles");

  chk_busy_ends: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(tmrRunning) |-> tmrDone && nvCmd.go && nvCmd.op != MODE_RESERVED)
    else $error("busy fell without completion");

  chk_read_data: assert property (@(posedge clk) disable iff (!reset_n)
    readGo ##1 1'b1 |=> s_q.data == $past(memRdata))
    else $error("read data not loaded");

  chk_addr_frozen: assert property (@(posedge clk) disable iff (!reset_n)
    busy |=> $stable(s_q.addr))
    else $error("address changed while busy");

  chk_reserved_idle: assert property (@(posedge clk) disable iff (!reset_n)
    launchTry && s_q.mode == MODE_RESERVED |=> !busy)
    else $error("reserved mode started programming");

  chk_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
    readGo |=> s_q.rdPend ##1 !s_q.rdPend)
    else $error("read strobe did not clear");

  cov_write_done: cover property (@(posedge clk) disable iff (!reset_n)
    writeGo ##[1:1000] 1'b1 ##0 tmrDone);
  cov_read: cover property (@(posedge clk) disable iff (!reset_n) readGo);
  cov_mpe_lapse: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(s_q.mpe) && !launchTry);
  cov_reserved: cover property (@(posedge clk) disable iff (!reset_n)
    launchTry && s_q.mode == MODE_RESERVED);
endmodule

// ### sim/eca_cpu_model.sv
// cpu core model issuing io space reads and writes to the access block
// assumes requests are sampled on the rising edge; drives on the falling edge
`timescale 1ns/1ps
module eca_cpu_model (
  // clock
  input wire logic clk,
  // io space
  output eca_pkg::eca_io_req_s io,
  input wire logic [7:0] ioRdData,
  input wire logic cpuStall
);
  import eca_pkg::*;

  initial io = '0;

  // time of the last release, so a following call can let one edge pass
  realtime relAt = -1.0;

  // a halted core issues nothing until the stall drops
  task automatic waitRun();
    int n;
    n = 0;
    // back to back calls idle one cycle so io is set only once per step
    if (relAt == $realtime) begin
      @(negedge clk);
    end
    while (cpuStall === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask

  // one-cycle pulse, released on the falling edge after it is taken
  task automatic ioWrite(logic [5:0] a, logic [7:0] d);
    waitRun();
    io = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge clk);
    io = '0;
    relAt = $realtime;
  endtask

  task automatic ioRead(logic [5:0] a, output logic [7:0] d);
    waitRun();
    io = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(negedge clk);
    d = ioRdData;
    io = '0;
    relAt = $realtime;
  endtask
endmodule

// ### sim/eca_access_ctrl_tb.sv
// self-checking bench for the array access block, cpu model as requester
// assumes shortened programming counts so a run stays brief
`timescale 1ns/1ps
module eca_access_ctrl_tb;
  import eca_pkg::*;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic gie = 1'b0;
  logic irqOn = 1'b0;
  eca_io_req_s io;
  logic [7:0] rd;
  logic stall;
  logic irq;
  int mismatches = 0;
  int nCompared = 0;

  eca_access_ctrl #(.ATOMIC_TICKS(16'h0028), .SPLIT_TICKS(16'h0014)) dut (
    .clk(clk), .reset_n(rstN), .io(io), .ioRdData(rd),
    .globalIrqEnable(gie), .cpuStall(stall), .readyIrq(irq));
  eca_cpu_model cpu (.clk(clk), .io(io), .ioRdData(rd), .cpuStall(stall));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(logic [7:0] seen, logic [7:0] exp, string what);
    nCompared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // control byte: mode, ready enable, then {master, program, read} strobes
  function automatic logic [7:0] ctl(logic [1:0] m, logic [2:0] s);
    return {2'b00, m, irqOn, s};
  endfunction

  task automatic rdCheck(logic [5:0] a, logic [7:0] exp, string what);
    logic [7:0] v;
    cpu.ioRead(a, v);
    check(v, exp, what);
  endtask

  task automatic stallLen(logic [7:0] exp);
    int n;
    n = 0;
    while (stall === 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    check(8'(n), exp, "stall length");
  endtask

  task automatic setAddr(logic [11:0] a);
    cpu.ioWrite(OFS_ADDR_HIGH, {4'h0, a[11:8]});
    cpu.ioWrite(OFS_ADDR_LOW, a[7:0]);
  endtask

  task automatic progByte(logic [1:0] m, logic [11:0] a, logic [7:0] d);
    setAddr(a);
    cpu.ioWrite(OFS_DATA, d);
    cpu.ioWrite(OFS_CONTROL, ctl(m, 3'b100));
    cpu.ioWrite(OFS_CONTROL, ctl(m, 3'b010));
    stallLen(8'(WRITE_STALL_CYCLES));
  endtask

  task automatic waitIdle();
    logic [7:0] v;
    int n;
    n = 0;
    v = 8'h02;
    while (v[BIT_PROG_STROBE] !== 1'b0 && n < 100) begin
      cpu.ioRead(OFS_CONTROL, v);
      n++;
    end
    check(v & 8'h02, 8'h00, "busy clears");
  endtask

  task automatic readByte(logic [11:0] a, logic [7:0] exp);
    setAddr(a);
    cpu.ioWrite(OFS_CONTROL, ctl(2'b00, 3'b001));
    stallLen(8'(READ_STALL_CYCLES));
    rdCheck(OFS_DATA, exp, "array byte");
    rdCheck(OFS_CONTROL, ctl(2'b00, 3'b000), "read strobe");
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // every test together is far below this span
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (12) @(negedge clk);
    rstN = 1'b1;
    rdCheck(OFS_CONTROL, 8'h00, "control reset");
    rdCheck(6'h23, 8'h00, "unmapped");
    cpu.ioWrite(OFS_ADDR_HIGH, 8'hFF);
    rdCheck(OFS_ADDR_HIGH, 8'h0F, "addr high");
    cpu.ioWrite(OFS_CONTROL, 8'hC8);
    rdCheck(OFS_CONTROL, 8'h08, "reserved bits");
    $display("test registers done");

    irqOn = 1'b1;
    gie = 1'b1;
    progByte(MODE_ERASE_WRITE, LAST_BYTE_ADDRESS, 8'hA5);
    check({7'h0, irq}, 8'h00, "irq busy");
    waitIdle();
    check({7'h0, irq}, 8'h01, "irq ready");
    gie = 1'b0;
    @(negedge clk);
    check({7'h0, irq}, 8'h00, "irq global");
    readByte(LAST_BYTE_ADDRESS, 8'hA5);
    progByte(MODE_WRITE, LAST_BYTE_ADDRESS, 8'h0F);
    waitIdle();
    readByte(LAST_BYTE_ADDRESS, 8'h05);
    progByte(MODE_ERASE, LAST_BYTE_ADDRESS, 8'h00);
    waitIdle();
    readByte(LAST_BYTE_ADDRESS, ERASED_BYTE);
    progByte(MODE_RESERVED, LAST_BYTE_ADDRESS, 8'h00);
    waitIdle();
    readByte(LAST_BYTE_ADDRESS, ERASED_BYTE);
    $display("test modes done");

    cpu.ioWrite(OFS_CONTROL, ctl(2'b00, 3'b010));
    rdCheck(OFS_CONTROL, ctl(2'b00, 3'b000), "no master");
    // strobe in the last open cycle, then one cycle late
    for (int gap = 3; gap <= 4; gap++) begin
      cpu.ioWrite(OFS_CONTROL, ctl(2'b00, 3'b100));
      repeat (gap) @(negedge clk);
      cpu.ioWrite(OFS_CONTROL, ctl(2'b00, 3'b010));
      rdCheck(OFS_CONTROL, ctl(2'b00, gap == 3 ? 3'b010 : 3'b000), "window");
      waitIdle();
    end
    $display("test enable window done");

    progByte(MODE_ERASE, 12'h005, 8'h00);
    cpu.ioWrite(OFS_CONTROL, ctl(MODE_RESERVED, 3'b001));
    stallLen(8'h00);
    cpu.ioWrite(OFS_ADDR_LOW, 8'h77);
    rdCheck(OFS_CONTROL, ctl(MODE_ERASE, 3'b010), "mode held");
    rdCheck(OFS_ADDR_LOW, 8'h05, "addr held");
    rstN = 1'b0;
    @(negedge clk);
    rstN = 1'b1;
    irqOn = 1'b0;
    rdCheck(OFS_CONTROL, 8'h12, "reset mid run");
    waitIdle();
    readByte(12'h005, ERASED_BYTE);
    $display("test busy guards done");
    summarize();
  end
endmodule
